// ==== hdl/ivp_pkg.sv ====
// Constants for the interrupt vector and priority block.
// Assumes an 8-bit core reading vectors over a 16-bit address bus.
// How it works
// - All vector bytes live between ffcc and ffff inclusive.
// - Each vector is two bytes: high byte even address, low byte next.
// - Timer A channel 5 at ffcc (lowest), channel 4 at ffce.
// - Converter at ffd0, keyboard at ffd2, SCI transmit at ffd4.
// - SCI receive at ffd6, SCI error at ffd8.
// - CAN transmit ffda, receive ffdc, error ffde, wakeup ffe0.
// - SPI transmit at ffe2, SPI receive at ffe4.
// - Timer B overflow ffe6, channel 1 ffe8, channel 0 ffea.
// - Timer A overflow ffec, channels 3,2,1,0 at ffee..fff4.
// - Tick timer fff6, PLL fff8, external pin fffa, swi fffc, reset fffe.
// - Priority rises with vector address; reset is highest.
package ivp_pkg;

    // ------------------------------------------------------------
    // Vector table geometry
    // ------------------------------------------------------------
    localparam int NUM_SRC = 26;
    localparam int SRC_W = 5;
    localparam logic [15:0] VEC_BASE = 16'hffcc;
    localparam logic [15:0] VEC_TOP = 16'hffff;
    localparam logic [15:0] RESET_VEC_ADDR = 16'hfffe;
    localparam logic [15:0] SWI_VEC_ADDR = 16'hfffc;
    localparam logic [SRC_W-1:0] SRC_RESET = 5'h19;
    localparam logic [SRC_W-1:0] SRC_SWI = 5'h18;
    localparam logic [SRC_W-1:0] SRC_NONE = 5'h00;

    // Source index n fetches from VEC_BASE + 2n; index 0 is timer A ch5
    localparam logic [SRC_W-1:0] SRC_TIMER_A_CH5 = 5'h00;
    localparam logic [SRC_W-1:0] SRC_TIMER_A_CH4 = 5'h01;
    localparam logic [SRC_W-1:0] SRC_ADC = 5'h02;
    localparam logic [SRC_W-1:0] SRC_KEYBOARD = 5'h03;
    localparam logic [SRC_W-1:0] SRC_SCI_TX = 5'h04;
    localparam logic [SRC_W-1:0] SRC_SCI_RX = 5'h05;
    localparam logic [SRC_W-1:0] SRC_SCI_ERR = 5'h06;
    localparam logic [SRC_W-1:0] SRC_CAN_TX = 5'h07;
    localparam logic [SRC_W-1:0] SRC_CAN_RX = 5'h08;
    localparam logic [SRC_W-1:0] SRC_CAN_ERR = 5'h09;
    localparam logic [SRC_W-1:0] SRC_CAN_WAKE = 5'h0a;
    localparam logic [SRC_W-1:0] SRC_SPI_TX = 5'h0b;
    localparam logic [SRC_W-1:0] SRC_SPI_RX = 5'h0c;
    localparam logic [SRC_W-1:0] SRC_TIMER_B_OVF = 5'h0d;
    localparam logic [SRC_W-1:0] SRC_TIMER_B_CH1 = 5'h0e;
    localparam logic [SRC_W-1:0] SRC_TIMER_B_CH0 = 5'h0f;
    localparam logic [SRC_W-1:0] SRC_TIMER_A_OVF = 5'h10;
    localparam logic [SRC_W-1:0] SRC_TIMER_A_CH3 = 5'h11;
    localparam logic [SRC_W-1:0] SRC_TIMER_A_CH2 = 5'h12;
    localparam logic [SRC_W-1:0] SRC_TIMER_A_CH1 = 5'h13;
    localparam logic [SRC_W-1:0] SRC_TIMER_A_CH0 = 5'h14;
    localparam logic [SRC_W-1:0] SRC_TICK = 5'h15;
    localparam logic [SRC_W-1:0] SRC_PLL = 5'h16;
    localparam logic [SRC_W-1:0] SRC_EXT_PIN = 5'h17;

    // Byte order inside one vector
    localparam logic HIGH_BYTE_OFS = 1'b0;
    localparam logic LOW_BYTE_OFS = 1'b1;

    // Fetch sequencer states
    typedef enum logic [1:0] {
        IVP_IDLE = 2'b00,
        IVP_HIGH = 2'b01,
        IVP_LOW = 2'b10,
        IVP_DONE = 2'b11
    } ivp_state_t;

    // Vector address of a source index: base plus twice the index
    function automatic logic [15:0] ivp_vec_addr(input logic [SRC_W-1:0] src);
        ivp_vec_addr = VEC_BASE + {10'h000, src, HIGH_BYTE_OFS};
    endfunction

endpackage

// ==== hdl/ivp_vec_rom.sv ====
// Vector byte store covering ffcc..ffff, one byte per address.
// Assumes the handler addresses are loaded as a parameter image at build.
`timescale 1ns/1ns
module ivp_vec_rom
    import ivp_pkg::*;
#(
    parameter logic [16*NUM_SRC-1:0] VEC_IMAGE = '0
) (
    input wire logic sys_clk_i, // System clock
    input wire logic reset_n_i, // Asynchronous reset, active low
    input wire logic [15:0] addr_i, // Byte address to read
    output logic [7:0] data_o // Registered read byte
);

    // ------------------------------------------------------------
    // Byte select
    // ------------------------------------------------------------
    logic [7:0] data_d;
    logic [7:0] data_q;
    logic [15:0] ofs;
    logic [15:0] word;

    // Addresses outside the table read as zero
    always_comb begin
        ofs = addr_i - VEC_BASE;
        word = VEC_IMAGE[16*ofs[SRC_W:1] +: 16];
        data_d = 8'h00;
        if (addr_i >= VEC_BASE && ofs[SRC_W:1] < NUM_SRC[SRC_W-1:0]) begin
            data_d = (ofs[0] == HIGH_BYTE_OFS) ? word[15:8] : word[7:0];
        end
    end

    // Read byte comes from a register
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            data_q <= 8'h00;
        end else begin
            data_q <= data_d;
        end
    end

    assign data_o = data_q;

endmodule

// ==== hdl/ivp_vector_ctrl.sv ====
// Priority encoder and vector fetch sequencer for the interrupt block.
// Assumes the core raises take_i for one cycle when it takes an interrupt
// and waits for vec_valid_o before loading its program counter.
`timescale 1ns/1ns
module ivp_vector_ctrl
    import ivp_pkg::*;
#(
    parameter logic [16*NUM_SRC-1:0] VEC_IMAGE = '0
) (
    input wire logic sys_clk_i, // System clock, 25 MHz
    input wire logic reset_n_i, // Asynchronous reset, active low
    input wire logic [NUM_SRC-3:0] irq_pend_i, // Peripheral requests, bit n = index n
    input wire logic [NUM_SRC-3:0] irq_en_i, // Per-source enables
    input wire logic swi_i, // Software interrupt instruction executing
    input wire logic take_i, // Core takes the pending request
    output logic irq_o, // Some enabled request pending
    output logic [SRC_W-1:0] src_o, // Winning source index
    output logic [15:0] fetch_addr_o, // Byte address being fetched
    output logic busy_o, // Fetch sequence running
    output logic vec_valid_o, // Handler address valid, one cycle
    output logic [15:0] vector_o // Handler address
);

    // ------------------------------------------------------------
    // Priority encode
    // ------------------------------------------------------------
    logic [NUM_SRC-3:0] live;
    logic [SRC_W-1:0] win;
    logic any;

    // Higher index scanned last so it wins
    always_comb begin
        live = irq_pend_i & irq_en_i;
        any = 1'b0;
        win = SRC_NONE;
        for (int i = 0; i < NUM_SRC - 2; i++) begin
            if (live[i]) begin
                any = 1'b1;
                win = i[SRC_W-1:0];
            end
        end
        if (swi_i) begin
            any = 1'b1;
            win = SRC_SWI;
        end
    end

    assign irq_o = any;

    // ------------------------------------------------------------
    // Fetch sequencer
    // ------------------------------------------------------------
    ivp_state_t st_d, st_q;
    logic [SRC_W-1:0] src_d, src_q;
    logic [15:0] addr_d, addr_q;
    logic [7:0] hi_d, hi_q;
    logic [15:0] vec_d, vec_q;
    logic [7:0] rom_data;
    logic first_d, first_q;

    // Reset vector is fetched once after reset, before any interrupt
    always_comb begin
        st_d = st_q;
        src_d = src_q;
        addr_d = addr_q;
        hi_d = hi_q;
        vec_d = vec_q;
        first_d = first_q;
        unique case (st_q)
            IVP_IDLE: begin
                if (first_q) begin
                    src_d = SRC_RESET;
                    addr_d = ivp_vec_addr(SRC_RESET);
                    st_d = IVP_HIGH;
                    first_d = 1'b0;
                end else if (take_i && any) begin
                    src_d = win;
                    addr_d = ivp_vec_addr(win);
                    st_d = IVP_HIGH;
                end
            end
            IVP_HIGH: begin
                addr_d = addr_q + {15'h0000, LOW_BYTE_OFS};
                st_d = IVP_LOW;
            end
            IVP_LOW: begin
                hi_d = rom_data;
                st_d = IVP_DONE;
            end
            IVP_DONE: begin
                vec_d = {hi_q, rom_data};
                st_d = IVP_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q <= IVP_IDLE;
            src_q <= SRC_NONE;
            addr_q <= RESET_VEC_ADDR;
            hi_q <= 8'h00;
            vec_q <= 16'h0000;
            first_q <= 1'b1;
        end else begin
            st_q <= st_d;
            src_q <= src_d;
            addr_q <= addr_d;
            hi_q <= hi_d;
            vec_q <= vec_d;
            first_q <= first_d;
        end
    end

    // Registered byte store, one cycle read latency
    ivp_vec_rom #(
        .VEC_IMAGE(VEC_IMAGE)
    ) u_rom (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .addr_i(addr_q),
        .data_o(rom_data)
    );

    // Valid is high for the cycle after the low byte lands
    logic valid_d, valid_q;
    always_comb begin
        valid_d = (st_q == IVP_DONE);
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            valid_q <= 1'b0;
        end else begin
            valid_q <= valid_d;
        end
    end

    assign vec_valid_o = valid_q;
    assign vector_o = vec_q;
    assign src_o = src_q;
    assign fetch_addr_o = addr_q;
    assign busy_o = (st_q != IVP_IDLE) || first_q;

endmodule

// ==== verification/ivp_vector_ctrl_sva.sv ====
// Checker for the vector fetch block, ports only.
// Assumes one clock and the async active-low reset.
`timescale 1ns/1ns
module ivp_vector_ctrl_sva
    import ivp_pkg::*;
(
    input wire logic sys_clk_i, // Clock
    input wire logic reset_n_i, // Reset
    input wire logic [NUM_SRC-3:0] irq_pend_i, // Requests
    input wire logic [NUM_SRC-3:0] irq_en_i, // Enables
    input wire logic swi_i, // Soft request
    input wire logic take_i, // Take
    input wire logic irq_o, // Pending
    input wire logic [SRC_W-1:0] src_o, // Winner
    input wire logic [15:0] fetch_addr_o, // Byte address
    input wire logic busy_o, // Busy
    input wire logic vec_valid_o, // Valid pulse
    input wire logic [15:0] vector_o // Handler
);
    // -----------------------------
    // Expected winner and accepted take
    // -----------------------------
    logic [SRC_W-1:0] win;
    logic take_ok;
    // Highest live index wins; soft request sits above every peripheral
    always_comb begin
        win = SRC_NONE;
        for (int n = 0; n < NUM_SRC - 2; n++) begin
            if (irq_pend_i[n] && irq_en_i[n]) win = SRC_W'(n);
        end
        if (swi_i) win = SRC_SWI;
    end
    assign take_ok = take_i && irq_o && !busy_o;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    a_take_answer: assert property (take_ok |-> ##4 vec_valid_o)
        else $error("no answer four cycles after take");
    a_valid_pulse: assert property (vec_valid_o |=> !vec_valid_o)
        else $error("valid longer than one cycle");
    a_winner_rank: assert property (take_ok |=> src_o == $past(win))
        else $error("wrong winning source");
    a_vec_even: assert property (take_ok |=>
        fetch_addr_o == VEC_BASE + {10'h000, $past(win), 1'b0}) else $error("bad vector address");
    a_low_next: assert property (take_ok |=> ##1 fetch_addr_o == $past(fetch_addr_o) + 16'h0001)
        else $error("low byte not at next address");
    a_fetch_range: assert property (busy_o |-> fetch_addr_o >= VEC_BASE)
        else $error("fetch outside vector area");
    a_irq_level: assert property (irq_o == ((|(irq_pend_i & irq_en_i)) || swi_i))
        else $error("pending flag wrong");
    a_src_hold: assert property (!busy_o && !take_ok |=> $stable(src_o))
        else $error("source changed while idle");
    c_swi: cover property (take_ok && swi_i);
    c_reset_vec: cover property (vec_valid_o && src_o == SRC_RESET);
    c_masked: cover property (take_ok && irq_pend_i[23] && !irq_en_i[23]);
endmodule
bind ivp_vector_ctrl ivp_vector_ctrl_sva u_sva (.sys_clk_i, .reset_n_i, .irq_pend_i, .irq_en_i,
    .swi_i, .take_i, .irq_o, .src_o, .fetch_addr_o, .busy_o, .vec_valid_o, .vector_o);

// ==== verification/ivp_core_model.sv ====
// Core model: takes one interrupt per request, after a wait.
// Assumes the block's take/valid handshake.
`timescale 1ns/1ns
module ivp_core_model (
    input wire logic sys_clk_i, // Clock
    input wire logic reset_n_i, // Reset
    input wire logic req_i, // Arm one take
    input wire logic [3:0] wait_i, // Cycles before taking
    input wire logic irq_i, // Pending from block
    input wire logic busy_i, // Block busy
    input wire logic vec_valid_i, // Answer pulse
    input wire logic [15:0] vector_i, // Handler
    output logic take_o, // Take pulse
    output logic done_o, // Answer received
    output logic [15:0] got_o // Captured handler
);
    logic arm_q, wt_q;
    logic [3:0] cnt_q;
    // Only takes while idle and pending, so never refused
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            {take_o, done_o, arm_q, wt_q, cnt_q, got_o} <= '0;
        end else begin
            take_o <= 1'b0;
            done_o <= 1'b0;
            if (req_i) arm_q <= 1'b1;
            if (wt_q && vec_valid_i) begin
                wt_q <= 1'b0;
                done_o <= 1'b1;
                got_o <= vector_i;
            end else if (arm_q && !wt_q && irq_i && !busy_i) begin
                cnt_q <= (cnt_q == wait_i) ? 4'h0 : cnt_q + 4'h1;
                if (cnt_q == wait_i) {take_o, wt_q, arm_q} <= 3'b110;
            end
        end
    end
endmodule

// ==== verification/interrupt_vector_priority_map_tb.sv ====
// Bench for the vector fetch block with a core model.
// Assumes a 25 MHz clock and synchronous stimulus.
`timescale 1ns/1ns
module interrupt_vector_priority_map_tb;
    import ivp_pkg::*;
    typedef struct {logic [23:0] p; logic [23:0] e; logic s; logic [4:0] w;} ivp_row_t;
    function automatic logic [16*NUM_SRC-1:0] mk_img();
        mk_img = '0;
        for (int n = 0; n < NUM_SRC; n++) mk_img[16*n+:16] = {8'(8'ha0 + n), 8'(8'h30 + n)};
    endfunction
    localparam logic [16*NUM_SRC-1:0] IMG = mk_img();
    logic clk = 1'b0, rst_n = 1'b0, software_interrupt_instruction = 1'b0, req = 1'b0, take, irq, busy, vv, done;
    logic [23:0] pend = '0, en = '0;
    logic [3:0] wt = 4'h0;
    logic [4:0] src;
    logic [15:0] fa, vec, got;
    int n_errors = 0, compares = 0;
    ivp_row_t rows[28];
    ivp_vector_ctrl #(.VEC_IMAGE(IMG)) uut (.sys_clk_i(clk), .reset_n_i(rst_n),
        .irq_pend_i(pend), .irq_en_i(en), .swi_i(software_interrupt_instruction), .take_i(take), .irq_o(irq),
        .src_o(src), .fetch_addr_o(fa), .busy_o(busy), .vec_valid_o(vv), .vector_o(vec));
    ivp_core_model u_core (.sys_clk_i(clk), .reset_n_i(rst_n), .req_i(req), .wait_i(wt),
        .irq_i(irq), .busy_i(busy), .vec_valid_i(vv), .vector_i(vec), .take_o(take),
        .done_o(done), .got_o(got));
    initial forever #20 clk = ~clk;
    task wrap_up();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk_vec(input logic [15:0] a, input logic [15:0] b);
        compares++;
        if (a !== b) begin n_errors++; $display("[ERR] %0t got %h exp %h", $time, a, b); end
    endtask
    task chk_src(input logic [4:0] a, input logic [4:0] b);
        compares++;
        if (a !== b) begin n_errors++; $display("[ERR] %0t got %h exp %h", $time, a, b); end
    endtask
    // Bounded wait on a settled flag; a miss counts as a mismatch
    task automatic wait_hi(ref logic f);
        int k;
        k = 0;
        do begin @(posedge clk); #1; k++; end while (f !== 1'b1 && k < 60);
        if (f !== 1'b1) n_errors++;
    endtask
    // Reset asserted and released on clock edges, held six cycles
    task do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        chk_vec({15'h0, vv}, 16'h0000);
        chk_vec(fa, RESET_VEC_ADDR);
        chk_src(5'(busy), 5'h01);
        @(posedge clk);
        rst_n <= 1'b1;
        wait_hi(vv);
        chk_vec(vec, IMG[16*25+:16]);
        chk_src(src, SRC_RESET);
        @(posedge clk);
    endtask
    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        #(40 * 4000);
        n_errors++;
        wrap_up();
    end
    initial begin
        for (int n = 0; n < 24; n++) rows[n] = '{24'h1 << n, 24'hffffff, 1'b0, 5'(n)};
        rows[24] = '{24'hffffff, 24'hffffff, 1'b1, SRC_SWI};
        rows[25] = '{24'hffffff, 24'hffffff, 1'b0, SRC_EXT_PIN};
        rows[26] = '{24'hffffff, 24'h00001f, 1'b0, SRC_SCI_TX};
        rows[27] = '{24'h000003, 24'h000001, 1'b0, SRC_TIMER_A_CH5};
        do_reset();
        for (int i = 0; i < 28; i++) begin
            @(posedge clk);
            pend <= rows[i].p;
            en <= rows[i].e;
            software_interrupt_instruction <= rows[i].s;
            wt <= 4'(i % 5);
            req <= 1'b1;
            @(posedge clk);
            req <= 1'b0;
            wait_hi(done);
            chk_src(src, rows[i].w);
            chk_vec(got, IMG[16*rows[i].w+:16]);
            chk_vec(vec, IMG[16*rows[i].w+:16]);
            chk_vec(fa, VEC_BASE + 16'(2 * rows[i].w + 1));
            chk_src(5'(busy), 5'h00);
        end
        // Everything pending but masked: nothing offered
        @(posedge clk);
        pend <= 24'hffffff;
        en <= 24'h000000;
        software_interrupt_instruction <= 1'b0;
        @(posedge clk);
        #1;
        chk_src(5'(irq), 5'h00);
        do_reset();
        wrap_up();
    end
endmodule
